// >>> hw/mscr_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MSCR_REGS_SVH
`define MSCR_REGS_SVH

`define MSCR_ADDR_CAP 8'h02
`define MSCR_ADDR_RESET 8'h03
`define MSCR_ADDR_CFG 8'h04

`define MSCR_RESET_TRIG_BIT 0
`define MSCR_CFG_SYNC_BIT 15
`define MSCR_CFG_TXFCS_BIT 14
`define MSCR_CFG_CSAL_BIT 13
`define MSCR_CFG_ZAL_BIT 12
`define MSCR_CFG_LOW_MSB 11

`define MSCR_CFG_RST 16'h0006
`define MSCR_MIN_CHUNK_PAYLOAD_CODE_RST 3'h3
`define MSCR_VIEW_RST 19'h00000

`define MSCR_FRAME_LAST 6'h3F
`define MSCR_HDR_LAST 6'h1F
`define MSCR_WR_FLAG_BIT 31

`define MSCR_CLK_PERIOD_PS 4000
`define MSCR_CS_MIN_NS 100
`define MSCR_CS_MIN_CYC ((`MSCR_CS_MIN_NS * 1000 + `MSCR_CLK_PERIOD_PS - 1) / `MSCR_CLK_PERIOD_PS)
`define MSCR_DEVRST_CYC 16

`endif

// >>> hw/mscr_pkg.sv
// Types shared by the reset and configuration register bank
package mscr_pkg;

  // Layout matches configuration register bits 15 down to 0
  typedef struct packed {
    logic sync;
    logic tx_fcs_check_enable;
    logic cs_aligned_rx_enable;
    logic zero_aligned_rx_enable;
    logic [11:0] low_cfg;
  } mscr_cfg_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
  } mscr_cmd_t;

  // Read-visible state mirrored into the link domain
  typedef struct packed {
    mscr_cfg_t cfg;
    logic [2:0] min_chunk_payload_code;
  } mscr_view_t;

  typedef enum logic [1:0] {
    MSCR_IDLE,
    MSCR_ARMED,
    MSCR_FIRE
  } mscr_rst_state_t;

  function automatic logic [7:0] mscr_chunk_bytes(input logic [2:0] code);
    case (code)
      3'h6: mscr_chunk_bytes = 8'h40;
      3'h5: mscr_chunk_bytes = 8'h20;
      3'h4: mscr_chunk_bytes = 8'h10;
      3'h3: mscr_chunk_bytes = 8'h08;
      default: mscr_chunk_bytes = 8'h00;
    endcase
  endfunction

endpackage

// >>> hw/mscr_sync.sv
// Two-flop synchroniser for one level or toggle
`timescale 1ns/1ps
`default_nettype none
module mscr_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Destination clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Level from the other domain
  input wire logic i_d,
  output logic o_q
);
  logic meta_q;
  logic sync_q;

  // First stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;
endmodule // mscr_sync
`default_nettype wire

// >>> hw/mscr_top.sv
// SPI-reached reset and configuration register bank
// Summary of operation
// R1 - Capability field reports minimum chunk size code
// R2 - Codes 6,5,4,3 mean 64,32,16,8 bytes
// R3 - Chunk capabilities only valid under chunk protocol
// R4 - Writing reset bit resets whole device
// R5 - Reset waits for chip select deassertion
// R6 - Host holds chip select at least 100 ns
// R7 - Reset bit self-clears; register reads zero
// R8 - Sync bit copied into receive footers
// R9 - Sync bit is write-one-to-set only
// R10 - After reset: sync clear, flag, interrupt
// R11 - FCS check enable validates last four octets
// R12 - Host keeps CRC append off with FCS check
// R13 - Chip-select aligned receive frame start
// R14 - Zero aligned receive frame start
// R15 - Alignment options only under chunk protocol
// R16 - Config resets to 0x6, upper half zero
// R17 - Reserved bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
`include "mscr_regs.svh"
module mscr_top (
  // Device clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // SPI link
  input wire logic i_spi_sck,
  input wire logic i_spi_cs_b,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  // Protocol select level, high for chunk protocol
  input wire logic i_proto_chunk,
  // Reset-complete status
  input wire logic i_reset_complete_clr,
  output logic o_reset_complete_flag,
  output logic o_int_b,
  output logic o_dev_reset,
  // Configuration towards the datapath
  output logic o_rx_footer_sync,
  output logic o_tx_fcs_check_enable,
  output logic o_cs_aligned_rx_enable,
  output logic o_zero_aligned_rx_enable,
  output logic [11:0] o_low_cfg,
  output logic [7:0] o_min_chunk_bytes
);
  import mscr_pkg::*;

  // Link domain: command shifter
  logic [5:0] bit_cnt_q, bit_cnt_d;
  logic [31:0] sh_q, sh_d;
  logic [31:0] hdr_q, hdr_d;
  logic [31:0] out_q, out_d;
  logic miso_q, miso_d;
  logic oe_q, oe_d;
  // Link domain: handed-over command and mirrored view
  mscr_cmd_t cmd_q, cmd_d;
  logic wr_tog_q, wr_tog_d;
  mscr_view_t copy_q, copy_d;
  logic ack_q, ack_d;
  logic req_s;
  logic [31:0] rd_word;

  // Device domain
  logic cs_b_s, proto_s, wr_tog_s, ack_s;
  logic wr_seen_q, wr_seen_d;
  logic cs_prev_q, cs_prev_d;
  logic [4:0] cs_cnt_q, cs_cnt_d;
  logic cs_long_q, cs_long_d;
  mscr_rst_state_t state_q, state_d;
  logic [4:0] rst_cnt_q, rst_cnt_d;
  mscr_cfg_t cfg_q, cfg_d;
  logic rc_q, rc_d;
  logic int_b_q, int_b_d;
  logic csal_q, csal_d;
  logic zal_q, zal_d;
  logic [7:0] bytes_q, bytes_d;
  mscr_view_t snap_q, snap_d;
  mscr_view_t live;
  logic req_q, req_d;
  logic dev_rst_q, dev_rst_d;
  logic wr_stb, cs_fall, soft_clr;

  // Read data: reset register and unmapped offsets read zero
  always_comb begin
    case (hdr_d[7:0])
      `MSCR_ADDR_CAP: rd_word = {29'h0000000, copy_q.min_chunk_payload_code}; // R1
      `MSCR_ADDR_CFG: rd_word = {16'h0000, copy_q.cfg}; // R16
      default: rd_word = 32'h00000000; // R7
    endcase
  end

  // Mode 0: both directions move on the rising edge of the link clock
  always_comb begin
    bit_cnt_d = bit_cnt_q + 6'h01;
    sh_d = {sh_q[30:0], i_spi_mosi};
    hdr_d = hdr_q;
    out_d = {out_q[30:0], 1'b0};
    miso_d = out_q[31];
    oe_d = 1'b1;
    if (bit_cnt_q == `MSCR_HDR_LAST) begin
      hdr_d = sh_d;
      out_d = {rd_word[30:0], 1'b0};
      miso_d = rd_word[31];
    end
  end

  // Chip select high parks the shifter without needing link clock edges
  always_ff @(posedge i_spi_sck or posedge i_spi_cs_b) begin
    if (i_spi_cs_b) begin
      bit_cnt_q <= 6'h00;
      sh_q <= 32'h00000000;
      hdr_q <= 32'h00000000;
      out_q <= 32'h00000000;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      sh_q <= sh_d;
      hdr_q <= hdr_d;
      out_q <= out_d;
      miso_q <= miso_d;
      oe_q <= oe_d;
    end
  end

  // Command word stays put for 64 link clocks, far longer than the crossing
  always_comb begin
    cmd_d = cmd_q;
    wr_tog_d = wr_tog_q;
    copy_d = copy_q;
    ack_d = ack_q;
    if (bit_cnt_q == `MSCR_FRAME_LAST) begin
      cmd_d = '{wr: hdr_q[`MSCR_WR_FLAG_BIT], addr: hdr_q[7:0], data: sh_d};
      wr_tog_d = ~wr_tog_q;
    end
    if (req_s != ack_q) begin
      copy_d = snap_q;
      ack_d = req_s;
    end
  end

  always_ff @(posedge i_spi_sck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmd_q <= '0;
      wr_tog_q <= 1'b0;
      copy_q <= `MSCR_VIEW_RST;
      ack_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      wr_tog_q <= wr_tog_d;
      copy_q <= copy_d;
      ack_q <= ack_d;
    end
  end

  assign o_spi_miso = miso_q;
  assign o_spi_miso_oe = oe_q;

  // Crossings
  mscr_sync #(.RST_VAL(1'b1)) u_cs_sync (
    .i_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_d(i_spi_cs_b),
    .o_q(cs_b_s)
  );

  mscr_sync #(.RST_VAL(1'b0)) u_proto_sync (
    .i_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_d(i_proto_chunk),
    .o_q(proto_s)
  );

  mscr_sync #(.RST_VAL(1'b0)) u_wr_sync (
    .i_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_d(wr_tog_q),
    .o_q(wr_tog_s)
  );

  mscr_sync #(.RST_VAL(1'b0)) u_ack_sync (
    .i_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_d(ack_q),
    .o_q(ack_s)
  );

  mscr_sync #(.RST_VAL(1'b0)) u_req_sync (
    .i_clk(i_spi_sck),
    .i_rst_b(i_rst_b),
    .i_d(req_q),
    .o_q(req_s)
  );

  assign wr_stb = wr_tog_s ^ wr_seen_q;
  assign cs_fall = cs_prev_q & ~cs_b_s;
  assign soft_clr = (state_q == MSCR_FIRE) &&
                    (rst_cnt_q == 5'(`MSCR_DEVRST_CYC - 1));

  // Chip select low time, remembered until the next frame starts
  always_comb begin
    wr_seen_d = wr_tog_s;
    cs_prev_d = cs_b_s;
    cs_cnt_d = cs_cnt_q;
    cs_long_d = cs_long_q;
    if (cs_b_s || cs_fall) begin
      cs_cnt_d = 5'h00;
    end else if (cs_cnt_q != 5'(`MSCR_CS_MIN_CYC)) begin
      cs_cnt_d = cs_cnt_q + 5'h01;
    end
    if (cs_fall) begin
      cs_long_d = 1'b0;
    end else if (!cs_b_s && cs_cnt_q >= 5'(`MSCR_CS_MIN_CYC - 1)) begin
      cs_long_d = 1'b1; // R6
    end
  end

  // Software reset sequencer
  always_comb begin
    state_d = state_q;
    rst_cnt_d = rst_cnt_q;
    case (state_q)
      MSCR_IDLE: begin
        if (wr_stb && cmd_q.wr && cmd_q.addr == `MSCR_ADDR_RESET &&
            cmd_q.data[`MSCR_RESET_TRIG_BIT]) begin
          state_d = MSCR_ARMED; // R4
        end
      end
      MSCR_ARMED: begin
        // Short chip select drops the request
        if (cs_b_s) begin
          state_d = cs_long_q ? MSCR_FIRE : MSCR_IDLE; // R5
          rst_cnt_d = 5'h00;
        end
      end
      MSCR_FIRE: begin
        rst_cnt_d = rst_cnt_q + 5'h01;
        if (soft_clr) begin
          state_d = MSCR_IDLE; // R7
        end
      end
      default: begin
        state_d = MSCR_IDLE;
      end
    endcase
    // Flop copy of the state keeps the reset pin glitch free
    dev_rst_d = (state_d == MSCR_FIRE); // R4
  end

  // Configuration and status
  always_comb begin
    cfg_d = cfg_q;
    rc_d = rc_q;
    if (soft_clr) begin
      cfg_d = `MSCR_CFG_RST; // R10
    end else if (wr_stb && cmd_q.wr && cmd_q.addr == `MSCR_ADDR_CFG) begin
      cfg_d.sync = cfg_q.sync | cmd_q.data[`MSCR_CFG_SYNC_BIT]; // R9
      cfg_d.tx_fcs_check_enable = cmd_q.data[`MSCR_CFG_TXFCS_BIT];
      cfg_d.cs_aligned_rx_enable = cmd_q.data[`MSCR_CFG_CSAL_BIT];
      cfg_d.zero_aligned_rx_enable = cmd_q.data[`MSCR_CFG_ZAL_BIT];
      cfg_d.low_cfg = cmd_q.data[`MSCR_CFG_LOW_MSB:0]; // R17
    end
    // Reset event wins over a clear in the same cycle
    if (soft_clr) begin
      rc_d = 1'b1; // R10
    end else if (i_reset_complete_clr) begin
      rc_d = 1'b0;
    end
    int_b_d = ~rc_d; // R10
    csal_d = cfg_d.cs_aligned_rx_enable & proto_s; // R13 R15
    zal_d = cfg_d.zero_aligned_rx_enable & proto_s; // R14 R15
    bytes_d = proto_s ? mscr_chunk_bytes(`MSCR_MIN_CHUNK_PAYLOAD_CODE_RST) : 8'h00; // R2 R3
  end

  // Mirror of read-visible state, one full handshake at a time
  always_comb begin
    live = '{cfg: cfg_q, min_chunk_payload_code: proto_s ? `MSCR_MIN_CHUNK_PAYLOAD_CODE_RST : 3'h0}; // R1 R3
    snap_d = snap_q;
    req_d = req_q;
    if (req_q == ack_s && live != snap_q) begin
      snap_d = live;
      req_d = ~req_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      wr_seen_q <= 1'b0;
      cs_prev_q <= 1'b1;
      cs_cnt_q <= 5'h00;
      cs_long_q <= 1'b0;
      state_q <= MSCR_IDLE;
      rst_cnt_q <= 5'h00;
      cfg_q <= `MSCR_CFG_RST; // R16
      rc_q <= 1'b1; // R10
      int_b_q <= 1'b0;
      csal_q <= 1'b0;
      zal_q <= 1'b0;
      bytes_q <= 8'h00;
      snap_q <= `MSCR_VIEW_RST;
      req_q <= 1'b0;
      dev_rst_q <= 1'b0;
    end else begin
      wr_seen_q <= wr_seen_d;
      cs_prev_q <= cs_prev_d;
      cs_cnt_q <= cs_cnt_d;
      cs_long_q <= cs_long_d;
      state_q <= state_d;
      rst_cnt_q <= rst_cnt_d;
      cfg_q <= cfg_d;
      rc_q <= rc_d;
      int_b_q <= int_b_d;
      csal_q <= csal_d;
      zal_q <= zal_d;
      bytes_q <= bytes_d;
      snap_q <= snap_d;
      req_q <= req_d;
      dev_rst_q <= dev_rst_d;
    end
  end

  // Datapath consumes these; footer sync follows the stored bit directly
  assign o_rx_footer_sync = cfg_q.sync; // R8
  assign o_tx_fcs_check_enable = cfg_q.tx_fcs_check_enable; // R11
  assign o_cs_aligned_rx_enable = csal_q;
  assign o_zero_aligned_rx_enable = zal_q;
  assign o_low_cfg = cfg_q.low_cfg;
  assign o_min_chunk_bytes = bytes_q;
  assign o_reset_complete_flag = rc_q;
  assign o_int_b = int_b_q;
  assign o_dev_reset = dev_rst_q;
endmodule // mscr_top
`default_nettype wire

// >>> sim/mscr_top_monitor.sv
// Port assertions for the reset and configuration register bank
`timescale 1ns/1ps
`default_nettype none
module mscr_top_monitor (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Watched ports
  input wire logic i_spi_cs_b,
  input wire logic i_proto_chunk,
  input wire logic i_reset_complete_clr,
  input wire logic o_reset_complete_flag,
  input wire logic o_int_b,
  input wire logic o_dev_reset,
  input wire logic o_rx_footer_sync,
  input wire logic o_tx_fcs_check_enable,
  input wire logic o_cs_aligned_rx_enable,
  input wire logic o_zero_aligned_rx_enable,
  input wire logic [11:0] o_low_cfg,
  input wire logic [7:0] o_min_chunk_bytes
);
  // Length of the current device reset pulse
  logic [4:0] len_q;
  logic [4:0] len_d;
  always_comb begin
    len_d = (!i_rst_b || !o_dev_reset) ? 5'h00 : len_q + 5'h01;
  end
  always_ff @(posedge i_ref_clk) begin
    len_q <= len_d;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  property p_int;
    o_int_b == !o_reset_complete_flag;
  endproperty
  a_int: assert property (p_int) else $error("interrupt not tracking flag");
  property p_flag_clr;
    i_reset_complete_clr && !o_dev_reset |=> !o_reset_complete_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
  property p_sync_keep;
    o_rx_footer_sync && !o_dev_reset |=> o_rx_footer_sync;
  endproperty
  a_sync_keep: assert property (p_sync_keep) else $error("sync bit dropped");
  property p_gen;
    !i_proto_chunk [*4] |=> !o_cs_aligned_rx_enable && !o_zero_aligned_rx_enable
      && o_min_chunk_bytes == 8'h00;
  endproperty
  a_gen: assert property (p_gen) else $error("generic protocol not gating");
  property p_chunk;
    (i_proto_chunk && !o_dev_reset) [*4] |=> o_min_chunk_bytes == 8'h08;
  endproperty
  a_chunk: assert property (p_chunk) else $error("minimum chunk size wrong");
  property p_bytes;
    o_min_chunk_bytes == 8'h00 || o_min_chunk_bytes == 8'h08;
  endproperty
  a_bytes: assert property (p_bytes) else $error("chunk size decode wrong");
  property p_len;
    $fell(o_dev_reset) |-> len_q == 5'h10;
  endproperty
  a_len: assert property (p_len) else $error("device reset length wrong");
  property p_cs;
    $rose(o_dev_reset) |-> i_spi_cs_b && $past(i_spi_cs_b, 2);
  endproperty
  a_cs: assert property (p_cs) else $error("reset before chip select release");
  property p_vals;
    $fell(o_dev_reset) |-> !o_rx_footer_sync && !o_tx_fcs_check_enable
      && o_reset_complete_flag && o_low_cfg == 12'h006;
  endproperty
  a_vals: assert property (p_vals) else $error("reset values not restored");
  c_rst: cover property ($rose(o_dev_reset));
  c_sync: cover property ($rose(o_rx_footer_sync));
  c_gen: cover property ($fell(o_cs_aligned_rx_enable));
endmodule // mscr_top_monitor
bind mscr_top mscr_top_monitor u_mscr_top_monitor (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
  .i_spi_cs_b(i_spi_cs_b), .i_proto_chunk(i_proto_chunk),
  .i_reset_complete_clr(i_reset_complete_clr), .o_reset_complete_flag(o_reset_complete_flag),
  .o_int_b(o_int_b), .o_dev_reset(o_dev_reset), .o_rx_footer_sync(o_rx_footer_sync),
  .o_tx_fcs_check_enable(o_tx_fcs_check_enable),
  .o_cs_aligned_rx_enable(o_cs_aligned_rx_enable),
  .o_zero_aligned_rx_enable(o_zero_aligned_rx_enable), .o_low_cfg(o_low_cfg),
  .o_min_chunk_bytes(o_min_chunk_bytes));
`default_nettype wire

// >>> sim/mscr_spi_host.sv
// Behavioural SPI host issuing 64-bit command frames
`timescale 1ns/1ps
`default_nettype none
module mscr_spi_host (
  // Link pins towards the device
  output logic o_sck,
  output logic o_cs_b,
  output logic o_mosi,
  input wire logic i_miso
);
  initial begin
    o_sck = 1'b0;
    o_cs_b = 1'b1;
    o_mosi = 1'b0;
  end
  // Mode 0; clock stops between frames, hp sets fast or slow links
  task automatic xfer(input logic [63:0] f, input realtime hp, output logic [31:0] rd);
    rd = 32'h0;
    #7.3 o_cs_b = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      o_mosi = f[i];
      #(hp);
      if (i < 32) rd[i] = i_miso;
      o_sck = 1'b1;
      #(hp);
      o_sck = 1'b0;
    end
    #(hp);
    o_cs_b = 1'b1;
    // Released line must not look like held data
    o_mosi = ~o_mosi;
  endtask
endmodule // mscr_spi_host
`default_nettype wire

// >>> sim/tb_mscr_top.sv
// Self-checking bench for the reset and configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "mscr_regs.svh"
module tb_mscr_top;
  logic clk, rst_b, proto, clr, sck, cs_b, mosi;
  wire logic miso, miso_w, oe, flag, int_b, dev_rst, fsync, fcs, csal, zal;
  wire logic [11:0] low;
  wire logic [7:0] bytes;
  logic [31:0] rd;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  mscr_top u_mscr_top (.i_ref_clk(clk), .i_rst_b(rst_b), .i_spi_sck(sck), .i_spi_cs_b(cs_b),
    .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(oe), .i_proto_chunk(proto),
    .i_reset_complete_clr(clr), .o_reset_complete_flag(flag), .o_int_b(int_b),
    .o_dev_reset(dev_rst), .o_rx_footer_sync(fsync), .o_tx_fcs_check_enable(fcs),
    .o_cs_aligned_rx_enable(csal), .o_zero_aligned_rx_enable(zal), .o_low_cfg(low),
    .o_min_chunk_bytes(bytes));
  // Undriven line shows changing junk, not the last bit
  assign miso_w = oe ? miso : ~mosi;
  mscr_spi_host u_mscr_spi_host (.o_sck(sck), .o_cs_b(cs_b), .o_mosi(mosi), .i_miso(miso_w));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic end_of_test;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    u_mscr_spi_host.xfer({w, 23'h0, a, d}, 15.0, rd);
    repeat (8) @(negedge clk);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic t_reset;
    chk("flag_int", 32'h2, {flag, int_b});
    chk("cfg_out", 32'h006, {fsync, fcs, csal, zal, low});
    chk("bytes", 32'h08, bytes);
    rdc("cap", `MSCR_ADDR_CAP, 32'h3);
    rdc("cfg", `MSCR_ADDR_CFG, 32'h6);
    rdc("rst_reg", `MSCR_ADDR_RESET, 32'h0);
    rdc("unmapped", 8'h3C, 32'h0);
  endtask
  task automatic t_cfg;
    xf(1'b1, `MSCR_ADDR_CFG, 32'hFFFF_F009);
    chk("cfg_out", 32'hF009, {fsync, fcs, csal, zal, low});
    rdc("cfg_rsv", `MSCR_ADDR_CFG, 32'hF009);
    xf(1'b1, `MSCR_ADDR_CFG, 32'h0);
    chk("w1s_out", 32'h8000, {fsync, fcs, csal, zal, low});
    rdc("w1s", `MSCR_ADDR_CFG, 32'h8000);
  endtask
  task automatic t_generic;
    xf(1'b1, `MSCR_ADDR_CFG, 32'h3000);
    chk("align", 32'h3, {csal, zal});
    @(posedge clk) proto <= 1'b0;
    repeat (6) @(negedge clk);
    chk("align_gen", 32'h0, {csal, zal});
    chk("bytes_gen", 32'h0, bytes);
    rdc("cap_gen", `MSCR_ADDR_CAP, 32'h0);
    @(posedge clk) proto <= 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task automatic t_flag;
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (2) @(negedge clk);
    chk("flag_clr", 32'h1, {flag, int_b});
  endtask
  task automatic t_soft;
    int n;
    n = 0;
    xf(1'b1, `MSCR_ADDR_RESET, 32'hFFFF_FFFE);
    chk("no_rst", 32'h0, dev_rst);
    u_mscr_spi_host.xfer({1'b1, 23'h0, `MSCR_ADDR_RESET, 32'h1}, 15.0, rd);
    while (dev_rst !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("rst_seen", 32'h1, dev_rst);
    while (dev_rst === 1'b1 && n < 80) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    chk("rst_cfg", 32'h006, {fsync, fcs, csal, zal, low});
    chk("rst_flag", 32'h2, {flag, int_b});
    repeat (12) @(negedge clk);
    rdc("cfg_after", `MSCR_ADDR_CFG, 32'h6);
  endtask
  initial begin
    rst_b = 1'b0;
    proto = 1'b1;
    clr = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (12) @(negedge clk);
    t_reset();
    t_cfg();
    t_generic();
    t_flag();
    t_soft();
    end_of_test();
  end
endmodule // tb_mscr_top
`default_nettype wire
